// *** verilog/tcu_top.sv ***
// Timer compare unit: compare pair against a 16-bit timer count,
// pin set/clear/toggle, match flag and special event trigger.
// Assumes the timer count is a register on clk_in, the timer clock
// arrives as a pin level, and a port owner applies the direction bit.
`timescale 1ns/1ps
module tcu_top (
   // Clock and reset
   input  wire logic                  clk_in,
   input  wire logic                  arst_n_in,
   // Register port
   input  wire tcu_pkg::tcu_bus_req_t bus_in,
   output logic [7:0]                 rdata_out,
   // Timer side
   input  wire logic [15:0]           timer_count_in,
   input  wire logic                  timer_clk_in,
   output logic                       timer_reset_out,
   // Converter side
   input  wire logic                  adc_enable_in,
   output logic                       adc_start_out,
   // Events
   output logic                       special_trigger_out,
   output logic                       match_flag_out,
   // Pin side
   output logic                       pin_level_out,
   output logic                       pin_ctl_out
);

   // State of the unit except the edge detect and synchroniser registers
   typedef struct packed {
      logic [7:0]               control;
      logic [7:0]               value_low;
      logic [7:0]               value_high;
      logic [7:0]               rdata;
      logic                     flag;
      logic                     latch;
      logic                     pin_ctl;
      logic                     trigger;
      logic                     adc_start;
      logic                     timer_reset;
      logic                     tclk_prev;
      tcu_pkg::tcu_trig_state_t trig_state;
   } tcu_top_state_t;

   tcu_top_state_t st_ff;
   tcu_top_state_t nxt_st;

   // Decoded helpers
   logic [3:0]  mode;
   logic [15:0] compare_value;
   logic        equal;
   logic        match_rise;
   logic        tclk_level;
   logic        tclk_edge;
   logic        is_pin_mode;
   logic        is_cmp_mode;
   logic        wr_control;
   logic        wr_status;
   logic [7:0]  status_word;

   // Mode field and compare pair
   assign mode          = st_ff.control[tcu_pkg::MODE_LSB +: tcu_pkg::MODE_W];
   assign compare_value = {st_ff.value_high, st_ff.value_low};

   // Continuous equality with first-cycle detect
   tcu_edge u_edge (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .a_in      (compare_value),
      .b_in      (timer_count_in),
      .equal_out (equal),
      .rise_out  (match_rise)
   );

   // Timer clock is a pin level; bring it into clk_in
   tcu_sync u_tclk_sync (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .async_in  (timer_clk_in),
      .level_out (tclk_level)
   );

   // Rising edge of the filtered timer clock
   assign tclk_edge = tclk_level & ~st_ff.tclk_prev;

   // Mode classes: pin owners versus all compare modes
   always_comb begin
      is_pin_mode = 1'b0;
      is_cmp_mode = 1'b0;
      unique case (mode)
         tcu_pkg::MODE_TOGGLE,
         tcu_pkg::MODE_SET,
         tcu_pkg::MODE_CLEAR: begin
            is_pin_mode = 1'b1;
            is_cmp_mode = 1'b1;
         end
         tcu_pkg::MODE_IRQ,
         tcu_pkg::MODE_TRIGGER: begin
            is_cmp_mode = 1'b1;
         end
         default: begin
            is_pin_mode = 1'b0;
            is_cmp_mode = 1'b0;
         end
      endcase
   end

   // Write decode
   assign wr_control = bus_in.wr && (bus_in.addr == tcu_pkg::ADDR_CONTROL);
   assign wr_status  = bus_in.wr && (bus_in.addr == tcu_pkg::ADDR_STATUS);

   // Status word as seen by a read
   always_comb begin
      status_word                          = 8'h00;
      status_word[tcu_pkg::STAT_FLAG_BIT]  = st_ff.flag;
      status_word[tcu_pkg::STAT_PIN_BIT]   = st_ff.latch;
      status_word[tcu_pkg::STAT_PEND_BIT]  = (st_ff.trig_state == tcu_pkg::TRIG_PENDING);
      status_word[tcu_pkg::STAT_CTL_BIT]   = st_ff.pin_ctl;
   end

   // Next-state logic
   always_comb begin
      nxt_st             = st_ff;
      nxt_st.tclk_prev   = tclk_level;
      nxt_st.trigger     = 1'b0;
      nxt_st.adc_start   = 1'b0;
      nxt_st.timer_reset = 1'b0;

      // Register writes
      if (wr_control) begin
         nxt_st.control = bus_in.wdata;
      end
      if (bus_in.wr && (bus_in.addr == tcu_pkg::ADDR_VALUE_LOW)) begin
         nxt_st.value_low = bus_in.wdata;
      end
      if (bus_in.wr && (bus_in.addr == tcu_pkg::ADDR_VALUE_HIGH)) begin
         nxt_st.value_high = bus_in.wdata;
      end

      // Match flag clear by writing one; a new match below wins
      if (wr_status && bus_in.wdata[tcu_pkg::STAT_FLAG_BIT]) begin
         nxt_st.flag = 1'b0;
      end

      // Read data for the following cycle only
      nxt_st.rdata = tcu_pkg::RST_RDATA;
      if (bus_in.rd) begin
         unique case (bus_in.addr)
            tcu_pkg::ADDR_CONTROL:    nxt_st.rdata = st_ff.control;
            tcu_pkg::ADDR_VALUE_LOW:  nxt_st.rdata = st_ff.value_low;
            tcu_pkg::ADDR_VALUE_HIGH: nxt_st.rdata = st_ff.value_high;
            tcu_pkg::ADDR_STATUS:     nxt_st.rdata = status_word;
         endcase
      end

      // Pin ownership follows the mode
      nxt_st.pin_ctl = is_pin_mode;

      // Match actions, once per match
      if (match_rise && is_cmp_mode) begin
         nxt_st.flag = 1'b1;
         unique case (mode)
            tcu_pkg::MODE_TOGGLE: nxt_st.latch = ~st_ff.latch;
            tcu_pkg::MODE_SET:    nxt_st.latch = 1'b1;
            tcu_pkg::MODE_CLEAR:  nxt_st.latch = 1'b0;
            tcu_pkg::MODE_TRIGGER: begin
               nxt_st.trigger   = 1'b1;
               nxt_st.adc_start = adc_enable_in;
            end
            default: nxt_st.latch = st_ff.latch;
         endcase
      end

      // Pending timer reset waits for the next timer clock edge
      unique case (st_ff.trig_state)
         tcu_pkg::TRIG_IDLE: begin
            if (match_rise && (mode == tcu_pkg::MODE_TRIGGER)) begin
               nxt_st.trig_state = tcu_pkg::TRIG_PENDING;
            end
         end
         tcu_pkg::TRIG_PENDING: begin
            if (!equal || (mode != tcu_pkg::MODE_TRIGGER)) begin
               nxt_st.trig_state = tcu_pkg::TRIG_IDLE;
            end else if (tclk_edge) begin
               nxt_st.timer_reset = 1'b1;
               nxt_st.trig_state  = tcu_pkg::TRIG_IDLE;
            end
         end
      endcase

      // Zero control write drops the output latch, last so it wins
      if (wr_control && (bus_in.wdata == 8'h00)) begin
         nxt_st.latch = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff             <= '0;
         st_ff.control     <= tcu_pkg::RST_CONTROL;
         st_ff.value_low   <= tcu_pkg::RST_VALUE;
         st_ff.value_high  <= tcu_pkg::RST_VALUE;
         st_ff.rdata       <= tcu_pkg::RST_RDATA;
         st_ff.trig_state  <= tcu_pkg::TRIG_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register
   assign rdata_out           = st_ff.rdata;
   assign timer_reset_out     = st_ff.timer_reset;
   assign adc_start_out       = st_ff.adc_start;
   assign special_trigger_out = st_ff.trigger;
   assign match_flag_out      = st_ff.flag;
   assign pin_level_out       = st_ff.latch;
   assign pin_ctl_out         = st_ff.pin_ctl;

endmodule : tcu_top

// *** shared/tcu_pkg.sv ***
// Package for the timer compare unit: register map, field layout,
// reset values, compare mode codes and carrier types.
// Assumes an 8-bit register port with a 2-bit word address.
package tcu_pkg;

   // Register port and timer count widths
   localparam int unsigned ADDR_W = 2;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W  = 16;

   // Register addresses
   localparam logic [1:0] ADDR_CONTROL    = 2'h0;
   localparam logic [1:0] ADDR_VALUE_LOW  = 2'h1;
   localparam logic [1:0] ADDR_VALUE_HIGH = 2'h2;
   localparam logic [1:0] ADDR_STATUS     = 2'h3;

   // Reset values
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_VALUE   = 8'h00;
   localparam logic [7:0] RST_RDATA   = 8'h00;

   // Control field layout
   localparam int unsigned MODE_LSB = 0;
   localparam int unsigned MODE_W   = 4;

   // Status field layout
   localparam int unsigned STAT_FLAG_BIT = 0;
   localparam int unsigned STAT_PIN_BIT  = 1;
   localparam int unsigned STAT_PEND_BIT = 2;
   localparam int unsigned STAT_CTL_BIT  = 3;

   // Compare mode codes
   localparam logic [3:0] MODE_OFF     = 4'h0;
   localparam logic [3:0] MODE_TOGGLE  = 4'h2;
   localparam logic [3:0] MODE_SET     = 4'h8;
   localparam logic [3:0] MODE_CLEAR   = 4'h9;
   localparam logic [3:0] MODE_IRQ     = 4'ha;
   localparam logic [3:0] MODE_TRIGGER = 4'hb;

   // Synchroniser depth for pin inputs
   localparam int unsigned SYNC_STAGES = 3;

   // Register port request
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tcu_bus_req_t;

   // Trigger sequence states
   typedef enum logic [0:0] {
      TRIG_IDLE,
      TRIG_PENDING
   } tcu_trig_state_t;

endpackage : tcu_pkg

// *** verilog/tcu_sync.sv ***
// Three-stage synchroniser with agreement filter for one pin level.
// Assumes the input is asynchronous to clk_in.
`timescale 1ns/1ps
module tcu_sync (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   // Asynchronous level
   input  wire logic async_in,
   // Filtered level
   output logic      level_out
);

   typedef struct packed {
      logic [2:0] stage;
      logic       level;
   } tcu_sync_state_t;

   tcu_sync_state_t st_ff;
   tcu_sync_state_t nxt_st;

   // Shift in; accept a change once stages two and three agree
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.stage = {st_ff.stage[1:0], async_in};
      if (st_ff.stage[1] == st_ff.stage[2]) begin
         nxt_st.level = st_ff.stage[2];
      end
   end

   // State register
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level_out = st_ff.level;

endmodule : tcu_sync

// *** verilog/tcu_edge.sv ***
// Equality comparator with rising-edge detect.
// Assumes both operands are registered values on clk_in.
`timescale 1ns/1ps
module tcu_edge (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   // Operands
   input  wire logic [15:0] a_in,
   input  wire logic [15:0] b_in,
   // Results
   output logic             equal_out,
   output logic             rise_out
);

   typedef struct packed {
      logic equal_prev;
   } tcu_edge_state_t;

   tcu_edge_state_t st_ff;
   tcu_edge_state_t nxt_st;

   // Live equality and its first cycle
   always_comb begin
      equal_out         = (a_in == b_in);
      rise_out          = equal_out & ~st_ff.equal_prev;
      nxt_st            = st_ff;
      nxt_st.equal_prev = equal_out;
   end

   // State register
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule : tcu_edge

// *** bench/tcu_top_props.sv ***
// Port checker for the timer compare unit.
// Assumes it is bound into tcu_top and sees only its ports.
`timescale 1ns/1ps
module tcu_top_props (
   // Clock, reset and inputs
   input wire logic                  clk_in,
   input wire logic                  arst_n_in,
   input wire tcu_pkg::tcu_bus_req_t bus_in,
   input wire logic [15:0]           timer_count_in,
   input wire logic                  adc_enable_in,
   // Outputs watched
   input wire logic                  timer_reset_out,
   input wire logic                  adc_start_out,
   input wire logic                  special_trigger_out,
   input wire logic                  match_flag_out,
   input wire logic                  pin_level_out,
   input wire logic                  pin_ctl_out
);
   logic [15:0] val_ff;
   logic [3:0]  mode_ff;
   logic        eq_ff;
   logic        eq;
   logic        rise;
   // Shadow of compare pair, mode and last equality
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         val_ff <= 16'h0000;
         mode_ff <= 4'h0;
         eq_ff <= 1'b0;
      end else begin
         eq_ff <= eq;
         if (bus_in.wr && bus_in.addr == 2'h0) mode_ff <= bus_in.wdata[3:0];
         if (bus_in.wr && bus_in.addr == 2'h1) val_ff[7:0] <= bus_in.wdata;
         if (bus_in.wr && bus_in.addr == 2'h2) val_ff[15:8] <= bus_in.wdata;
      end
   end
   // First equal cycle outside register writes
   assign eq = val_ff == timer_count_in;
   assign rise = eq && !eq_ff && !bus_in.wr;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   property p_flag; rise && mode_ff inside {4'h2, 4'h8, 4'h9, 4'ha, 4'hb} |=> match_flag_out;
   endproperty
   a_flag: assert property (p_flag) else $error("flag missing after match");
   property p_set; rise && mode_ff == 4'h8 |=> pin_level_out; endproperty
   a_set: assert property (p_set) else $error("set mode left latch low");
   property p_clear; rise && mode_ff == 4'h9 |=> !pin_level_out; endproperty
   a_clear: assert property (p_clear) else $error("clear mode left latch high");
   property p_toggle; rise && mode_ff == 4'h2 |=> pin_level_out != $past(pin_level_out);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle mode did not toggle");
   property p_irq; rise && mode_ff == 4'ha |=> $stable(pin_level_out) && !pin_ctl_out;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt mode touched pin");
   property p_trig;
      rise && mode_ff == 4'hb |=> special_trigger_out && adc_start_out == $past(adc_enable_in);
   endproperty
   a_trig: assert property (p_trig) else $error("trigger or start missing");
   property p_once;
      eq && eq_ff && !match_flag_out |=> !match_flag_out && !special_trigger_out;
   endproperty
   a_once: assert property (p_once) else $error("event repeated while equal");
   property p_zero; bus_in.wr && bus_in.addr == 2'h0 && bus_in.wdata == 8'h00 |=> !pin_level_out;
   endproperty
   a_zero: assert property (p_zero) else $error("latch not low after zero write");
   property p_reset; timer_reset_out |-> eq_ff ##1 !timer_reset_out; endproperty
   a_reset: assert property (p_reset) else $error("timer reset without match");
   c_trig: cover property (rise && mode_ff == 4'hb);
   c_reset: cover property (timer_reset_out);
   c_toggle: cover property (rise && mode_ff == 4'h2);
endmodule : tcu_top_props

bind tcu_top tcu_top_props u_props (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus_in),
   .timer_count_in(timer_count_in), .adc_enable_in(adc_enable_in),
   .timer_reset_out(timer_reset_out), .adc_start_out(adc_start_out),
   .special_trigger_out(special_trigger_out), .match_flag_out(match_flag_out),
   .pin_level_out(pin_level_out), .pin_ctl_out(pin_ctl_out));

// *** bench/tcu_timer_model.sv ***
// Timer partner: 16-bit count ticking on a divided timer clock.
// Assumes reset_in is a one-cycle pulse on clk_in.
`timescale 1ns/1ps
module tcu_timer_model (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   // Load from bench, reset from unit
   input  wire logic        load_in,
   input  wire logic [15:0] load_val_in,
   input  wire logic        reset_in,
   // Timer state
   output logic [15:0]      count_out,
   output logic             tclk_out,
   output logic             ovf_out
);
   logic [2:0] div_ff;
   // Divided timer clock, count on its falling edge
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         div_ff <= 3'h0;
         tclk_out <= 1'b0;
         count_out <= 16'h0000;
         ovf_out <= 1'b0;
      end else begin
         div_ff <= div_ff + 3'h1;
         if (div_ff == 3'h7) tclk_out <= !tclk_out;
         if (load_in) count_out <= load_val_in;
         else if (reset_in) count_out <= 16'h0000;
         else if (div_ff == 3'h7 && tclk_out) begin
            count_out <= count_out + 16'h0001;
            if (count_out == 16'hffff) ovf_out <= 1'b1;
         end
      end
   end
endmodule : tcu_timer_model

// *** bench/tcu_top_tb.sv ***
// Testbench for the timer compare unit against an integer model.
// Assumes the timer model supplies count and timer clock.
`timescale 1ns/1ps
module tcu_top_tb;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   tcu_pkg::tcu_bus_req_t bus = '0;
   logic adc_en = 1'b0;
   logic pin_direction_bit = 1'b0;
   logic load = 1'b0;
   logic [15:0] load_val = 16'h0000;
   logic [15:0] count;
   logic tclk, ovf, trst, adc_start, trig, flag, pin, ctl, seen;
   logic [7:0] rdata, d;
   logic [3:0] modes [7] = '{4'h8, 4'h2, 4'h8, 4'h9, 4'h2, 4'ha, 4'hb};
   int mismatches = 0;
   int comparisons = 0;
   int exp_pin = 0;
   logic [15:0] v;
   // Clock
   always #2.5 clk_in = ~clk_in;
   tcu_top dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus), .rdata_out(rdata),
      .timer_count_in(count), .timer_clk_in(tclk), .timer_reset_out(trst),
      .adc_enable_in(adc_en), .adc_start_out(adc_start), .special_trigger_out(trig),
      .match_flag_out(flag), .pin_level_out(pin), .pin_ctl_out(ctl));
   tcu_timer_model tmr (.clk_in(clk_in), .arst_n_in(arst_n_in), .load_in(load),
      .load_val_in(load_val), .reset_in(trst), .count_out(count), .tclk_out(tclk),
      .ovf_out(ovf));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [1:0] a, input logic [7:0] w);
      @(posedge clk_in);
      bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a, output logic [7:0] q);
      @(posedge clk_in);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus.rd <= 1'b0;
      #1 q = rdata;
   endtask : rd
   // Mode, timer one tick short of the new compare pair
   task automatic arm(input logic [3:0] m);
      v = 16'h0002 + 16'($urandom % 32'hfff0);
      wr(tcu_pkg::ADDR_CONTROL, {4'h0, m});
      @(posedge clk_in);
      load <= 1'b1;
      load_val <= v - 16'h0001;
      @(posedge clk_in);
      load <= 1'b0;
      wr(tcu_pkg::ADDR_VALUE_LOW, v[7:0]);
      wr(tcu_pkg::ADDR_VALUE_HIGH, v[15:8]);
   endtask : arm
   task automatic report_and_stop();
      if (mismatches == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop
   // Main sequence
   initial begin
      void'($urandom(14));
      repeat (5) @(posedge clk_in);
      arst_n_in <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         rd(a[1:0], d);
         chk(d, tcu_pkg::RST_VALUE);
      end
      v = 16'($urandom);
      wr(tcu_pkg::ADDR_VALUE_LOW, v[7:0]);
      wr(tcu_pkg::ADDR_VALUE_HIGH, v[15:8]);
      rd(tcu_pkg::ADDR_VALUE_LOW, d);
      chk(d, v[7:0]);
      rd(tcu_pkg::ADDR_VALUE_HIGH, d);
      chk(d, v[15:8]);
      foreach (modes[i]) begin
         @(posedge clk_in);
         adc_en <= 1'($urandom);
         arm(modes[i]);
         for (int n = 0; n < 40 && flag !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
         end
         if (modes[i] == 4'h8) exp_pin = 1;
         if (modes[i] == 4'h9) exp_pin = 0;
         if (modes[i] == 4'h2) exp_pin = 1 - exp_pin;
         chk(flag, 1'b1);
         chk(pin & ~pin_direction_bit, exp_pin[0]);
         chk(ctl, modes[i] inside {4'h2, 4'h8, 4'h9});
         chk(trig, modes[i] == 4'hb);
         chk(adc_start, adc_en && modes[i] == 4'hb);
         wr(tcu_pkg::ADDR_STATUS, 8'h01);
         rd(tcu_pkg::ADDR_STATUS, d);
         chk(d[1:0], {exp_pin[0], 1'b0});
      end
      for (int n = 0; n < 30 && trst !== 1'b1; n++) begin
         @(posedge clk_in);
         #1;
      end
      chk(trst, 1'b1);
      @(posedge clk_in);
      #1;
      chk(count, 16'h0000);
      chk(ovf, 1'b0);
      arm(4'hb);
      for (int n = 0; n < 40 && trig !== 1'b1; n++) begin
         @(posedge clk_in);
         #1;
      end
      // Move the pair below the count so the timer never meets it again here
      wr(tcu_pkg::ADDR_VALUE_LOW, v[7:0] - 8'h01);
      seen = 1'b0;
      repeat (30) begin
         @(posedge clk_in);
         #1 seen = seen | trst;
      end
      chk(seen, 1'b0);
      wr(tcu_pkg::ADDR_CONTROL, 8'h00);
      #1;
      chk(pin, 1'b0);
      report_and_stop();
   end
   // Watchdog
   initial begin
      #20000;
      mismatches++;
      report_and_stop();
   end
endmodule : tcu_top_tb
